// File: dv/atb_far_end.sv
// trigger logic and interpolator stand-in
`timescale 1ns/1ps
`default_nettype none
module atb_far_end #(parameter logic [7:0] STRETCH = 8'h14) (
    input wire logic       sys_clk, resetn, arm_out, interp_pulse,
    input wire logic [3:0] trig_wait,
    output var logic       trig_in, interp_done
);
    logic [7:0] cnt_reg;
    logic       pend_reg;
    // wait trig_wait cycles after arming, stretch once the pulse ends
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            {trig_in, interp_done, pend_reg} <= 3'h0;
            cnt_reg <= 8'h00;
        end else begin
            {trig_in, interp_done} <= 2'h0;
            cnt_reg <= cnt_reg + 8'h01;
            if (arm_out && !pend_reg) begin
                if (cnt_reg == {4'h0, trig_wait}) trig_in <= 1'b1;
                // the stretch count starts at the trigger and restarts while interp_pulse is still high
                if (trig_in) begin
                    pend_reg <= 1'b1;
                    cnt_reg  <= 8'h00;
                end
            end else if (pend_reg && !interp_pulse) begin
                if (cnt_reg == STRETCH) begin
                    interp_done <= 1'b1;
                    pend_reg <= 1'b0;
                end
            end else cnt_reg <= 8'h00; // pulse still open: restart stretch
        end
    end
endmodule // atb_far_end
`default_nettype wire

// File: dv/atb_properties.sv
// port checker for the acquisition time base
`timescale 1ns/1ps
`default_nettype none
`include "atb_map.vh"
module atb_props #(parameter CNT_W = 16, DIV_W = 16, FINE_W = 20) (
    // clock, reset and processor control
    input wire logic              sys_clk, resetn, acq_start,
    input wire logic [2:0]        rate_sel,
    input wire logic [DIV_W-1:0]  div_ratio,
    input wire logic [CNT_W-1:0]  pre_count, post_count,
    // trigger, interpolator and status
    input wire logic              trig_in, arm_out, interp_pulse, interp_done,
    input wire logic              ref_sel, sample_en, acq_busy, acq_done,
    input wire logic [FINE_W-1:0] fine_count
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // rate is held while busy, so the source must match it throughout
    top_rate_ref_a: assert property (
        acq_busy && rate_sel <= `ATB_RATE_200M |-> ref_sel)
        else $error("ref_sel low at top rate");
    slow_rate_div_a: assert property (
        acq_busy && rate_sel > `ATB_RATE_200M |-> !ref_sel)
        else $error("ref_sel high at slow rate");
    gate_in_run_a: assert property (
        sample_en |-> acq_busy)
        else $error("sample gate open while idle");
    zero_pre_arm_a: assert property (
        acq_start && pre_count == 16'h0000 |=> arm_out)
        else $error("no arm after empty pre count");
    trig_disarm_a: assert property (
        arm_out && trig_in && !acq_start |=> !arm_out)
        else $error("arm kept after trigger");
    done_halts_a: assert property (
        acq_done |-> !sample_en && !arm_out)
        else $error("sampling after done");
    done_holds_a: assert property (
        acq_done && !acq_start |=> acq_done && $stable(fine_count))
        else $error("done or fine count moved");
    start_clears_a: assert property (
        acq_start |=> !acq_done)
        else $error("done kept over restart");
    // every clock is a sample edge at the top rates: no gap to measure
    pulse_top_rate_a: assert property (
        acq_busy && rate_sel <= `ATB_RATE_200M |-> !interp_pulse)
        else $error("interpolator pulse at top rate");
    start_busy_a: assert property (
        acq_start |=> acq_busy)
        else $error("not busy after start");
    cover property ($rose(acq_done));
    cover property (arm_out && trig_in);
    cover property ($fell(interp_pulse));
endmodule // atb_props
bind atb_time_base atb_props #(.CNT_W(CNT_W), .DIV_W(DIV_W),
    .FINE_W(FINE_W)) u_props (.sys_clk(sys_clk), .resetn(resetn),
    .acq_start(acq_start), .rate_sel(rate_sel), .div_ratio(div_ratio),
    .pre_count(pre_count), .post_count(post_count), .trig_in(trig_in),
    .arm_out(arm_out), .interp_pulse(interp_pulse),
    .interp_done(interp_done), .ref_sel(ref_sel), .sample_en(sample_en),
    .acq_busy(acq_busy), .acq_done(acq_done), .fine_count(fine_count));
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench for the acquisition time base
`timescale 1ns/1ps
`default_nettype none
`include "atb_map.vh"
module testbench;
    logic        sys_clk = 1'b0, resetn = 1'b0, acq_start = 1'b0, arm_prev;
    logic [2:0]  rate_sel = 3'h0;
    logic [3:0]  trig_wait = 4'h0;
    logic [15:0] div_ratio = 16'h0000, pre_count = 16'h0000;
    logic [15:0] post_count = 16'h0000;
    logic [31:0] seed = 32'h00008DE6;
    wire logic   trig_in, interp_done, arm_out, interp_pulse;
    wire logic   ref_sel, sample_en, acq_busy, acq_done;
    wire logic [19:0] fine_count;
    logic        exp_q[$];
    logic        done_prev;
    logic [19:0] fine_q[$], fine_max;
    localparam logic [7:0] STRETCH = 8'h14;
    int          n_errors = 0, compares = 0;
    always #50 sys_clk = ~sys_clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input string what, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        if (n_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    atb_time_base uut (.sys_clk(sys_clk), .resetn(resetn),
        .acq_start(acq_start), .rate_sel(rate_sel), .div_ratio(div_ratio),
        .pre_count(pre_count), .post_count(post_count), .trig_in(trig_in),
        .arm_out(arm_out), .interp_pulse(interp_pulse),
        .interp_done(interp_done), .ref_sel(ref_sel), .sample_en(sample_en),
        .acq_busy(acq_busy), .acq_done(acq_done), .fine_count(fine_count));
    atb_far_end #(.STRETCH(STRETCH)) far (.sys_clk(sys_clk),
        .resetn(resetn), .arm_out(arm_out),
        .interp_pulse(interp_pulse), .trig_wait(trig_wait),
        .trig_in(trig_in), .interp_done(interp_done));
    // every rate code once, then again with fresh random counts
    initial begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            seed = xs(seed);
            rate_sel <= 3'(i);
            div_ratio <= {14'h0000, seed[1:0]};
            pre_count <= {13'h0000, seed[4:2]};
            post_count <= {13'h0000, seed[7:5]};
            trig_wait <= seed[11:8];
            acq_start <= 1'b1;
            exp_q.push_back(3'(i) <= `ATB_RATE_200M);
            // stretch plus one, plus at most one divider period when slow
            fine_q.push_back({12'h000, STRETCH} + 20'h00001 +
                ((3'(i) <= `ATB_RATE_200M) ? 20'h00000 : {18'h0, seed[1:0]}));
            @(posedge sys_clk) acq_start <= 1'b0;
            // old done clears only at this edge, so look after it
            @(negedge sys_clk);
            for (int k = 0; k < 600 && acq_done !== 1'b1; k++)
                @(negedge sys_clk);
            check("acq_done", acq_done, 1'b1);
        end
        repeat (4) @(negedge sys_clk);
        check("pending arms", exp_q.size(), 0);
        check("pending fines", fine_q.size(), 0);
        wrap_up();
    end
    // outputs are looked at mid-cycle, where they have settled
    always @(negedge sys_clk) begin
        arm_prev <= arm_out;
        done_prev <= acq_done;
        if (arm_out === 1'b1 && arm_prev === 1'b0)
            check("ref_sel", ref_sel, exp_q.pop_front());
        if (acq_done === 1'b1 && done_prev === 1'b0) begin
            fine_max = fine_q.pop_front();
            check("fine_nonzero", fine_count != 20'h00000, 1'b1);
            check("fine_count", fine_count <= fine_max &&
                fine_count > {12'h000, STRETCH}, 1'b1);
            check("acq_busy", acq_busy, 1'b0);
        end
    end
    initial begin
        #(30000 * 100);
        n_errors++;
        wrap_up();
    end
endmodule // testbench
`default_nettype wire

// File: verilog/atb_map.vh
// constants for the acquisition time base
`ifndef ATB_MAP_VH
`define ATB_MAP_VH
`define ATB_RATE_W      3
`define ATB_RATE_400M   3'h0
`define ATB_RATE_200M   3'h1
`define ATB_CNT_W       16
`define ATB_DIV_W       16
`define ATB_FINE_W      20
`define ATB_PRE_RESET   16'h0000
`define ATB_POST_RESET  16'h0000
`define ATB_FINE_RESET  20'h00000
`define ATB_STRETCH     375
`endif

// File: verilog/atb_time_base.v
// acquisition time base: sample clock gating, pre/post counts, fine timer
//
// Operation
// - at the two top rates the sample clock comes straight from reference
// - at 100 MHz and slower the sample clock comes from the divider
// - clock gating is synchronised so only whole pulses reach converter
// - programmable dividers make the remaining sample rates from reference
// - separate counters set pre-trigger and post-trigger sample counts
// - after pre-trigger samples are taken, arm goes to the trigger logic
// - on trigger, post-trigger counter counts down from programmed count
// - at zero, sampling halts; acquisition-complete goes to processor once the fine counter stops
// - after trigger, pulse to interpolator lasts until next sample edge
// - fine counter runs on the sample clock while interpolator stretches
// - fine counter stops at interpolator done; its count is kept
`timescale 1ns/1ps
`default_nettype none
`include "atb_map.vh"

module atb_time_base #(
    parameter CNT_W  = `ATB_CNT_W,
    parameter DIV_W  = `ATB_DIV_W,
    parameter FINE_W = `ATB_FINE_W
) (
    // clock and reset
    input  wire                   sys_clk,
    input  wire                   resetn,
    // processor control; rate, divider and counts held steady during an acquisition
    input  wire                   acq_start,
    input  wire [`ATB_RATE_W-1:0] rate_sel,
    input  wire [DIV_W-1:0]       div_ratio,
    input  wire [CNT_W-1:0]       pre_count,
    input  wire [CNT_W-1:0]       post_count,
    // trigger logic
    input  wire                   trig_in,
    output reg                    arm_out,
    // fine interpolator
    output reg                    interp_pulse,
    input  wire                   interp_done,
    // converter sample clock source select and enable
    output reg                    ref_sel,
    output reg                    sample_en,
    // processor status
    output reg                    acq_busy,
    output reg                    acq_done,
    output reg  [FINE_W-1:0]      fine_count
);

    // the processor holds rate_sel, div_ratio and both counts steady from
    // acq_start to acq_done; changes mid-run are not supported
    // fine_count counts sys_clk cycles, standing in for the sample-rate
    // clock, and stops only on interp_done once interp_pulse has ended
    // limitation: a lost interp_done keeps the run busy until a new start

    // one-hot acquisition states
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_PRE  = 5'h02;
    localparam [4:0] ST_ARM  = 5'h04;
    localparam [4:0] ST_POST = 5'h08;
    localparam [4:0] ST_DONE = 5'h10;

    reg [4:0]        state_reg;
    reg [4:0]        state_next;
    reg [DIV_W-1:0]  div_reg;
    reg [CNT_W-1:0]  pre_reg;
    reg [CNT_W-1:0]  post_reg;
    reg              fine_run_reg;
    reg              trig_seen_reg;
    wire             div_tick;
    wire             sample_tick;
    wire             top_rate;
    wire             tick_ahead;
    wire             post_spent;

    // true when the rate code selects one of the two reference rates
    function is_top_rate;
        input [`ATB_RATE_W-1:0] code;
        begin
            is_top_rate = (code == `ATB_RATE_400M) ||
                          (code == `ATB_RATE_200M);
        end
    endfunction

    assign top_rate = is_top_rate(rate_sel);
    assign div_tick = (div_reg == {DIV_W{1'b0}});
    // one sample per divider wrap; at top rates every edge is a sample
    assign sample_tick = top_rate ? 1'b1 : div_tick;
    // a sample falls in the coming cycle; a start reloads the divider
    assign tick_ahead = top_rate || (div_ratio == {DIV_W{1'b0}}) ||
                        (!acq_start &&
                         div_reg == {{(DIV_W-1){1'b0}}, 1'b1});
    // no post-trigger samples left once this edge has passed
    assign post_spent = (state_next == ST_POST) &&
                        ((post_reg == {CNT_W{1'b0}}) ||
                         (state_reg == ST_POST && sample_tick &&
                          post_reg == {{(CNT_W-1){1'b0}}, 1'b1}));

    // divider, free running but reloaded at every start so its phase is known
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            div_reg <= {DIV_W{1'b0}};
        end else if (acq_start || div_tick) begin
            div_reg <= div_ratio;
        end else begin
            div_reg <= div_reg - {{(DIV_W-1){1'b0}}, 1'b1};
        end
    end

    // acquisition sequence
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                state_next = state_reg;
            end
            ST_PRE: begin
                if (sample_tick && pre_reg <= {{(CNT_W-1){1'b0}}, 1'b1})
                    state_next = ST_ARM;
            end
            ST_ARM: begin
                if (trig_in)
                    state_next = ST_POST;
            end
            ST_POST: begin
                // done waits for the fine count as well, so the processor
                // never reads a count that is still moving
                if (post_reg == {CNT_W{1'b0}} && !fine_run_reg)
                    state_next = ST_DONE;
            end
            ST_DONE: begin
                state_next = state_reg;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (acq_start)
            state_next = (pre_count == {CNT_W{1'b0}}) ? ST_ARM : ST_PRE;
    end

    // state and counters
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            pre_reg   <= `ATB_PRE_RESET;
            post_reg  <= `ATB_POST_RESET;
        end else begin
            state_reg <= state_next;
            if (acq_start) begin
                pre_reg  <= pre_count;
                post_reg <= post_count;
            end else begin
                if (state_reg == ST_PRE && sample_tick)
                    pre_reg <= pre_reg - {{(CNT_W-1){1'b0}}, 1'b1};
                if (state_reg == ST_POST && sample_tick &&
                        post_reg != {CNT_W{1'b0}})
                    post_reg <= post_reg - {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // sample enable: changes only on a clock edge and only at sample ticks,
    // so the gated converter clock never sees a truncated pulse
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sample_en <= 1'b0;
            ref_sel   <= 1'b0;
        end else begin
            ref_sel   <= top_rate;
            sample_en <= (state_next == ST_PRE || state_next == ST_ARM ||
                          state_next == ST_POST) &&
                         tick_ahead && !post_spent;
        end
    end

    // arm, interpolator pulse and fine interval counter
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            arm_out       <= 1'b0;
            interp_pulse  <= 1'b0;
            trig_seen_reg <= 1'b0;
            fine_run_reg  <= 1'b0;
            fine_count    <= `ATB_FINE_RESET;
        end else if (acq_start) begin
            arm_out       <= (state_next == ST_ARM);
            interp_pulse  <= 1'b0;
            trig_seen_reg <= 1'b0;
            fine_run_reg  <= 1'b0;
            fine_count    <= `ATB_FINE_RESET;
        end else begin
            arm_out <= (state_next == ST_ARM);
            // pulse from trigger until the next sample edge
            if (state_reg == ST_ARM && trig_in && !trig_seen_reg) begin
                trig_seen_reg <= 1'b1;
                interp_pulse  <= ~sample_tick;
                fine_run_reg  <= 1'b1;
            end else if (interp_pulse && sample_tick) begin
                interp_pulse <= 1'b0;
            end
            // count sample-rate clocks until the stretch is over
            if (fine_run_reg) begin
                if (interp_done && !interp_pulse)
                    fine_run_reg <= 1'b0;
                else
                    fine_count <= fine_count +
                                  {{(FINE_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // status to processor
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            acq_busy <= 1'b0;
            acq_done <= 1'b0;
        end else begin
            acq_busy <= (state_next != ST_IDLE) && (state_next != ST_DONE);
            acq_done <= (state_next == ST_DONE);
        end
    end

endmodule // atb_time_base
`default_nettype wire
